// >>> logic/sps_bank.sv
// Scratch memory with read-only status area at its top.
// Assumes command and polling inputs come from logic on clk.
`timescale 1ns/10ps
`include "sps_defines.svh"

module sps_bank
    import sps_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Command port
    input  wire logic        cmdValid,
    input  wire logic        cmdWrite,
    input  wire logic        cmdWord,
    input  wire logic [7:0]  cmdAddr,
    input  wire logic [7:0]  cmdWrData,
    output logic             cmdReady,
    output logic             rdValid,
    output logic [15:0]      rdData,
    output logic             cmdErr,
    // Program slots
    input  wire logic [3:0]  runSlot,
    input  wire logic [3:0]  dataSlot,
    // Polling logic
    input  wire logic [15:0] trigMain,
    input  wire logic [15:0] trigAux,
    input  wire logic        pollModeCmd,
    input  wire logic [3:0]  pollModeCode,
    input  wire logic        pollOutEnable,
    input  wire logic        pollRunEnable,
    input  wire logic        pollRunCmd,
    input  wire logic [2:0]  pollRunSlot,
    input  wire logic        auxGroupActive,
    input  wire logic        polledInputsDefined,
    input  wire logic        latchMode,
    input  wire logic        signalLatched,
    input  wire logic        pollWaitEvent,
    input  wire logic        pollingActive
);

    ////////////////////////////////////////////////////////////////
    // Address map

    localparam logic [7:0] SLOT_LOC = LARGE_VARIANT ?
        `SPS_LOC_SLOT_LARGE : `SPS_LOC_SLOT_SMALL;
    localparam logic [7:0] LAST_LOC = LARGE_VARIANT ?
        `SPS_LOC_POLL_STATE : `SPS_LOC_SLOT_SMALL;

    function automatic logic isGeneral(input logic [7:0] a);
        isGeneral = (a < SLOT_LOC);
    endfunction

    function automatic logic inRange(input logic [7:0] a);
        inRange = (a <= LAST_LOC);
    endfunction

    ////////////////////////////////////////////////////////////////
    // State

    sps_state_t  state_r;
    sps_state_t  state_nxt;
    logic [7:0]  addr_r;
    logic [7:0]  addr_nxt;
    logic        word_r;
    logic        err_r;
    logic        err_nxt;
    logic [7:0]  loByte_r;
    logic [3:0]  mode_r;
    logic [2:0]  runSel_r;
    logic        outEn_r;
    logic        runEn_r;
    logic        waitFlag_r;
    logic        waitFlag_nxt;
    logic        cmdReady_r;
    logic        rdValid_r;
    logic [15:0] rdData_r;
    logic        cmdErr_r;

    sps_mem_if memBus ();

    sps_mem u_mem (
        .clk  (clk),
        .port (memBus.store)
    );

    ////////////////////////////////////////////////////////////////
    // Command decode

    wire accept   = cmdValid && cmdReady_r;
    wire wrAccept = accept && cmdWrite;
    wire rdAccept = accept && !cmdWrite;
    // Status area and unmapped locations refuse writes
    wire wrLegal  = isGeneral(cmdAddr);
    wire rdLegal  = inRange(cmdAddr);

    // Only the command port reaches the store
    assign memBus.we    = wrAccept && wrLegal;
    assign memBus.addr  = wrAccept ? cmdAddr[`SPS_MEM_AW-1:0]
                        : (isGeneral(addr_r) ? addr_r[`SPS_MEM_AW-1:0]
                                             : {`SPS_MEM_AW{1'b0}});
    assign memBus.wdata = cmdWrData;

    ////////////////////////////////////////////////////////////////
    // Status bytes

    wire anyTrig = (|trigMain) || (|trigAux);

    wire [7:0] slotByte = LARGE_VARIANT ? {dataSlot, runSlot}
                                        : {4'h0, runSlot};

    wire [7:0] pollState = {
        pollingActive,
        waitFlag_r,
        signalLatched,
        anyTrig,
        latchMode,
        runEn_r,
        polledInputsDefined,
        outEn_r
    };

    logic [7:0] statByte;
    always_comb begin
        case (addr_r)
            `SPS_LOC_TRIG_MAIN_LO: statByte = trigMain[7:0];
            `SPS_LOC_TRIG_MAIN_HI: statByte = trigMain[15:8];
            `SPS_LOC_TRIG_AUX_LO:  statByte = trigAux[7:0];
            `SPS_LOC_TRIG_AUX_HI:  statByte = trigAux[15:8];
            `SPS_LOC_POLL_MODE:    statByte = {4'h0, mode_r};
            `SPS_LOC_RUN_SLOT:     statByte = {5'h00, runSel_r};
            `SPS_LOC_PIN_GROUP:    statByte = {7'h00, auxGroupActive};
            `SPS_LOC_POLL_STATE:   statByte = pollState;
            default:               statByte = 8'h00;
        endcase
    end

    // Slot location overrides stored data: always the live slot
    wire [7:0] pickByte = !inRange(addr_r) ? 8'h00
                        : isGeneral(addr_r) ? memBus.rdata
                        : (addr_r == SLOT_LOC) ? slotByte
                        : statByte;

    wire [7:0] nextAddr = addr_r + 8'h01;
    wire       hiLegal  = inRange(nextAddr) && (addr_r != 8'hFF);

    ////////////////////////////////////////////////////////////////
    // Read sequencer

    always_comb begin
        state_nxt = state_r;
        addr_nxt  = addr_r;
        err_nxt   = err_r;
        case (state_r)
            ST_IDLE: begin
                if (rdAccept) begin
                    state_nxt = ST_FETCH_LO;
                    addr_nxt  = cmdAddr;
                    err_nxt   = !rdLegal;
                end
            end
            ST_FETCH_LO: state_nxt = ST_TAKE_LO;
            ST_TAKE_LO: begin
                if (word_r) begin
                    state_nxt = ST_FETCH_HI;
                    addr_nxt  = nextAddr;
                    err_nxt   = err_r || !hiLegal;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_FETCH_HI: state_nxt = ST_TAKE_HI;
            ST_TAKE_HI:  state_nxt = ST_IDLE;
            default:     state_nxt = ST_IDLE;
        endcase
    end

    wire finish  = (state_r == ST_TAKE_HI) ||
                   ((state_r == ST_TAKE_LO) && !word_r);
    wire [15:0] result = (state_r == ST_TAKE_HI)
                       ? {pickByte, loByte_r}
                       : {8'h00, pickByte};

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            addr_r  <= 8'h00;
            err_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r  <= addr_nxt;
            err_r   <= err_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            word_r   <= 1'b0;
            loByte_r <= 8'h00;
        end else begin
            if (rdAccept) begin
                word_r <= cmdWord;
            end
            if (state_r == ST_TAKE_LO) begin
                loByte_r <= pickByte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Answer registers

    always_ff @(posedge clk) begin
        if (rst) begin
            cmdReady_r <= 1'b0;
            rdValid_r  <= 1'b0;
            rdData_r   <= 16'h0000;
            cmdErr_r   <= 1'b0;
        end else begin
            cmdReady_r <= (state_nxt == ST_IDLE);
            rdValid_r  <= finish;
            if (finish) begin
                rdData_r <= result;
            end
            // Refused write or unmapped read, one-cycle pulse
            cmdErr_r <= (wrAccept && !wrLegal) || (finish && err_r);
        end
    end

    assign cmdReady = cmdReady_r;
    assign rdValid  = rdValid_r;
    assign rdData   = rdData_r;
    assign cmdErr   = cmdErr_r;

    ////////////////////////////////////////////////////////////////
    // Polling configuration

    // Event wins over the clearing command in the same cycle
    assign waitFlag_nxt = pollWaitEvent ||
                          (waitFlag_r && !pollModeCmd);

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r     <= `SPS_RST_MODE;
            runSel_r   <= `SPS_RST_RUN_SLOT;
            outEn_r    <= 1'b0;
            runEn_r    <= 1'b0;
            waitFlag_r <= 1'b0;
        end else begin
            if (pollModeCmd) begin
                mode_r  <= pollModeCode;
                outEn_r <= pollOutEnable;
                runEn_r <= pollRunEnable;
            end
            if (pollRunCmd) begin
                runSel_r <= pollRunSlot;
            end
            waitFlag_r <= waitFlag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks

    sequence byteRd(logic [7:0] loc);
        rdAccept && !cmdWord && (cmdAddr == loc) && inRange(loc);
    endsequence

    sequence wordRd;
        rdAccept && cmdWord;
    endsequence

    a_status_no_write: assert property (@(posedge clk) disable iff (rst)
        (wrAccept && !isGeneral(cmdAddr)) |-> !memBus.we)
        else $error("status location written");

    a_slot_nibble: assert property (@(posedge clk) disable iff (rst)
        byteRd(SLOT_LOC) |-> ##3 (rdValid && rdData[3:0] == $past(runSlot)))
        else $error("slot nibble not current");

    a_trig_main_lo: assert property (@(posedge clk) disable iff (rst)
        byteRd(`SPS_LOC_TRIG_MAIN_LO)
        |-> ##3 (rdValid && rdData[7:0] == $past(trigMain[7:0])))
        else $error("trigger byte wrong");

    a_mode_taken: assert property (@(posedge clk) disable iff (rst)
        pollModeCmd ##1 byteRd(`SPS_LOC_POLL_MODE)
        |-> ##3 (rdValid && rdData[3:0] == $past(pollModeCode, 4)))
        else $error("mode nibble wrong");

    a_run_slot: assert property (@(posedge clk) disable iff (rst)
        pollRunCmd |=> (runSel_r == $past(pollRunSlot)))
        else $error("run slot not taken");

    a_wait_set: assert property (@(posedge clk) disable iff (rst)
        pollWaitEvent |=> waitFlag_r [*1] ##0 pollState[`SPS_BIT_WAIT])
        else $error("wait flag not set");

    a_wait_hold: assert property (@(posedge clk) disable iff (rst)
        (waitFlag_r && !pollModeCmd) |=> waitFlag_r)
        else $error("wait flag lost");

    a_word_read: assert property (@(posedge clk) disable iff (rst)
        wordRd |=> !rdValid [*4] ##1 rdValid)
        else $error("word read timing");

    a_store_back: assert property (@(posedge clk) disable iff (rst)
        (wrAccept && wrLegal) ##1 (byteRd($past(cmdAddr)))
        |-> ##3 (rdValid && rdData[7:0] == $past(cmdWrData, 4)))
        else $error("stored byte lost");

    a_byte_answer: assert property (@(posedge clk) disable iff (rst)
        (rdAccept && !cmdWord) |=> !rdValid [*2] ##1 rdValid)
        else $error("byte read timing");

    a_read_busy: assert property (@(posedge clk) disable iff (rst)
        wordRd |=> !cmdReady [*4] ##1 cmdReady)
        else $error("word read busy window");

    a_slot_small: assert property (@(posedge clk) disable iff (rst)
        (rdAccept && !cmdWord && cmdAddr == `SPS_LOC_SLOT_SMALL && !LARGE_VARIANT)
        |-> ##3 (rdData == {12'h000, $past(runSlot)}))
        else $error("small slot byte wrong");

    a_slot_large: assert property (@(posedge clk) disable iff (rst)
        (rdAccept && !cmdWord && cmdAddr == `SPS_LOC_SLOT_LARGE && LARGE_VARIANT)
        |-> ##3 (rdData == {8'h00, $past(dataSlot), $past(runSlot)}))
        else $error("large slot byte wrong");

    a_run_sel_read: assert property (@(posedge clk) disable iff (rst)
        byteRd(`SPS_LOC_RUN_SLOT)
        |-> ##3 (rdData == {13'h0000, $past(runSel_r)}))
        else $error("run slot byte wrong");

    a_pin_group: assert property (@(posedge clk) disable iff (rst)
        byteRd(`SPS_LOC_PIN_GROUP)
        |-> ##3 (rdData == {15'h0000, $past(auxGroupActive)}))
        else $error("pin group byte wrong");

    a_any_trig: assert property (@(posedge clk) disable iff (rst)
        byteRd(`SPS_LOC_POLL_STATE)
        |-> ##3 (rdData[`SPS_BIT_ANY_TRIG] == $past((|trigMain) || (|trigAux))))
        else $error("any trigger bit wrong");

    a_polling_bit: assert property (@(posedge clk) disable iff (rst)
        byteRd(`SPS_LOC_POLL_STATE)
        |-> ##3 (rdData[`SPS_BIT_POLLING] == $past(pollingActive)))
        else $error("polling bit wrong");

    a_err_refused: assert property (@(posedge clk) disable iff (rst)
        (wrAccept && !wrLegal) |=> cmdErr)
        else $error("refused write not flagged");

endmodule

// >>> logic/sps_defines.svh
// Constants of the scratch memory and its status area.
// Assumes one clock, byte-wide locations, 8-bit location numbers.
//
// Notes on behaviour
// - Scratch memory reached only by its read and write commands, never by name.
// - Small variant: location 63 low nibble holds running program slot.
// - Large variant: location 127 holds running slot low, data slot high.
// - Locations 128-131 hold per-pin trigger flags: main lo, main hi, aux lo, hi.
// - Location 132 low nibble shows last polling-mode command mode.
// - Location 133 low three bits show polled-run slot.
// - Location 134 bit 0 shows active pin group, 1 means auxiliary.
// - Location 135 bit 0 shows polled outputs enabled.
// - Location 135 bit 1 shows at least one polled input defined.
// - Location 135 bit 2 shows polled-run action enabled.
// - Location 135 bit 3 shows latch mode, 0 is real-time.
// - Location 135 bit 4 reads 1 while any polled input triggered.
// - Location 135 bit 5 reads 1 once an output signal latched.
// - Location 135 bit 6 set by poll-wait event, cleared only by polling-mode command.
// - Location 135 bit 7 reads 1 while polling active.
// - Running-slot nibble is read-only and always current.
// - Word read fetches two sequential locations, low byte first.
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

`define SPS_LOC_SLOT_SMALL 8'h3F
`define SPS_LOC_SLOT_LARGE 8'h7F
`define SPS_LOC_TRIG_MAIN_LO 8'h80
`define SPS_LOC_TRIG_MAIN_HI 8'h81
`define SPS_LOC_TRIG_AUX_LO 8'h82
`define SPS_LOC_TRIG_AUX_HI 8'h83
`define SPS_LOC_POLL_MODE 8'h84
`define SPS_LOC_RUN_SLOT 8'h85
`define SPS_LOC_PIN_GROUP 8'h86
`define SPS_LOC_POLL_STATE 8'h87
`define SPS_MEM_DEPTH 127
`define SPS_MEM_AW 7

`define SPS_BIT_OUT_EN 0
`define SPS_BIT_IN_DEF 1
`define SPS_BIT_RUN_EN 2
`define SPS_BIT_LATCH_MODE 3
`define SPS_BIT_ANY_TRIG 4
`define SPS_BIT_LATCHED 5
`define SPS_BIT_WAIT 6
`define SPS_BIT_POLLING 7

`define SPS_RST_MODE 4'h0
`define SPS_RST_RUN_SLOT 3'h0

`endif

// >>> logic/sps_mem.sv
// General-purpose byte store of the scratch memory.
// Assumes addresses below the depth; read data registered.
`timescale 1ns/10ps
`include "sps_defines.svh"

module sps_mem (
    // Clock
    input wire logic clk,
    // Store side
    sps_mem_if.store port
);

    logic [7:0] cells [0:`SPS_MEM_DEPTH-1];

    // No reset: contents are undefined until written
    always_ff @(posedge clk) begin
        if (port.we) begin
            cells[port.addr] <= port.wdata;
        end
        port.rdata <= cells[port.addr];
    end

endmodule

// >>> logic/sps_mem_if.sv
// Link between the controller and its byte store.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`include "sps_defines.svh"

interface sps_mem_if;
    logic                     we;
    logic [`SPS_MEM_AW-1:0]   addr;
    logic [7:0]               wdata;
    logic [7:0]               rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface

// >>> logic/sps_pkg.sv
// Types shared by the scratch memory block.
// Assumes sps_defines.svh for all figures.
package sps_pkg;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'h01,
        ST_FETCH_LO = 5'h02,
        ST_TAKE_LO  = 5'h04,
        ST_FETCH_HI = 5'h08,
        ST_TAKE_HI  = 5'h10
    } sps_state_t;

    typedef logic [7:0] sps_byte_t;

endpackage

// >>> verif/sps_bank_test.sv
// Self-checking bench for the scratch memory with status area.
// Assumes sps_bank ports as declared; inputs change on falling edges.
`timescale 1ns/10ps
`include "sps_defines.svh"

module sps_bank_test;
    logic        clk, rst, cmdValid, cmdWrite, cmdWord;
    logic [7:0]  cmdAddr, cmdWrData;
    logic        cmdReady, rdValid, cmdErr, cmdReady2, rdValid2, cmdErr2;
    logic [15:0] rdData, rdData2, trigMain, trigAux;
    logic [3:0]  runSlot, dataSlot, pollModeCode;
    logic [2:0]  pollRunSlot;
    logic        pollModeCmd, pollOutEnable, pollRunEnable, pollRunCmd;
    logic        auxGroupActive, polledInputsDefined, latchMode, signalLatched;
    logic        pollWaitEvent, pollingActive, lastE2;
    logic [15:0] lastD2;
    int          failures, total_checks, cycles;

    // Both variants see the same stimulus; the small one's answers are kept aside
    sps_bank #(.LARGE_VARIANT(1'b1)) u_sps_bank (.clk(clk), .rst(rst), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdWord(cmdWord), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData),
        .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData), .cmdErr(cmdErr),
        .runSlot(runSlot), .dataSlot(dataSlot), .trigMain(trigMain), .trigAux(trigAux),
        .pollModeCmd(pollModeCmd), .pollModeCode(pollModeCode), .pollOutEnable(pollOutEnable),
        .pollRunEnable(pollRunEnable), .pollRunCmd(pollRunCmd), .pollRunSlot(pollRunSlot),
        .auxGroupActive(auxGroupActive), .polledInputsDefined(polledInputsDefined),
        .latchMode(latchMode), .signalLatched(signalLatched), .pollWaitEvent(pollWaitEvent),
        .pollingActive(pollingActive));
    sps_bank #(.LARGE_VARIANT(1'b0)) u_sps_bank_small (.clk(clk), .rst(rst), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdWord(cmdWord), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData),
        .cmdReady(cmdReady2), .rdValid(rdValid2), .rdData(rdData2), .cmdErr(cmdErr2),
        .runSlot(runSlot), .dataSlot(dataSlot), .trigMain(trigMain), .trigAux(trigAux),
        .pollModeCmd(pollModeCmd), .pollModeCode(pollModeCode), .pollOutEnable(pollOutEnable),
        .pollRunEnable(pollRunEnable), .pollRunCmd(pollRunCmd), .pollRunSlot(pollRunSlot),
        .auxGroupActive(auxGroupActive), .polledInputsDefined(polledInputsDefined),
        .latchMode(latchMode), .signalLatched(signalLatched), .pollWaitEvent(pollWaitEvent),
        .pollingActive(pollingActive));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, well above the eighty or so cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Write stays requested on return so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic expErr);
        int n;
        n = 0;
        while (cmdReady !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk({15'h0000, cmdReady}, 16'h0001, "ready for write");
        cmdValid  = 1'b1;
        cmdWrite  = 1'b1;
        cmdWord   = 1'b0;
        cmdAddr   = a;
        cmdWrData = d;
        @(negedge clk);
        chk({15'h0000, cmdErr}, {15'h0000, expErr}, "write error flag");
    endtask

    task automatic rd(input logic [7:0] a, input logic w, input logic [15:0] exp,
                      input logic expErr);
        int n;
        n = 0;
        while (cmdReady !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        cmdValid = 1'b1;
        cmdWrite = 1'b0;
        cmdWord  = w;
        cmdAddr  = a;
        @(negedge clk);
        cmdValid = 1'b0;
        chk({15'h0000, cmdReady}, 16'h0000, "busy after read");
        n = 0;
        while (rdValid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        lastD2 = rdData2;
        lastE2 = cmdErr2;
        chk({15'h0000, rdValid}, 16'h0001, "read answer");
        chk(rdData, exp, "read data");
        chk({15'h0000, cmdErr}, {15'h0000, expErr}, "read error flag");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_general();
        wr(8'h00, 8'h5A, 1'b0);
        wr(8'h01, 8'hC3, 1'b0);
        wr(8'h7E, 8'hA5, 1'b0);
        rd(8'h7E, 1'b0, 16'h00A5, 1'b0);
        rd(8'h00, 1'b0, 16'h005A, 1'b0);
        rd(8'h00, 1'b1, 16'hC35A, 1'b0);
        $display("test general done");
    endtask

    task automatic t_slot();
        runSlot  = 4'h5;
        dataSlot = 4'h9;
        wr(`SPS_LOC_SLOT_LARGE, 8'hFF, 1'b1);
        rd(`SPS_LOC_SLOT_LARGE, 1'b0, 16'h0095, 1'b0);
        runSlot = 4'h2;
        rd(`SPS_LOC_SLOT_LARGE, 1'b0, 16'h0092, 1'b0);
        wr(`SPS_LOC_SLOT_SMALL, 8'h3C, 1'b0);
        wr(8'h40, 8'h66, 1'b0);
        rd(`SPS_LOC_SLOT_SMALL, 1'b0, 16'h003C, 1'b0);
        chk(lastD2, 16'h0002, "small slot nibble");
        rd(8'h40, 1'b0, 16'h0066, 1'b0);
        chk({15'h0000, lastE2}, 16'h0001, "small unmapped read");
        chk(lastD2, 16'h0000, "small unmapped data");
        $display("test slot done");
    endtask

    task automatic t_trig();
        trigMain = 16'h8001;
        trigAux  = 16'h2C40;
        rd(`SPS_LOC_TRIG_MAIN_LO, 1'b0, 16'h0001, 1'b0);
        rd(`SPS_LOC_TRIG_MAIN_LO, 1'b1, 16'h8001, 1'b0);
        rd(`SPS_LOC_TRIG_AUX_LO, 1'b1, 16'h2C40, 1'b0);
        $display("test trig done");
    endtask

    task automatic t_poll();
        pollModeCode   = 4'hA;
        pollOutEnable  = 1'b1;
        pollRunEnable  = 1'b0;
        pollModeCmd    = 1'b1;
        pollRunSlot    = 3'h6;
        pollRunCmd     = 1'b1;
        auxGroupActive = 1'b1;
        pollWaitEvent  = 1'b1;
        @(negedge clk);
        pollModeCmd   = 1'b0;
        pollRunCmd    = 1'b0;
        pollWaitEvent = 1'b0;
        polledInputsDefined = 1'b1;
        signalLatched = 1'b1;
        pollingActive = 1'b1;
        rd(`SPS_LOC_POLL_MODE, 1'b0, 16'h000A, 1'b0);
        rd(`SPS_LOC_RUN_SLOT, 1'b0, 16'h0006, 1'b0);
        rd(`SPS_LOC_POLL_MODE, 1'b1, 16'h060A, 1'b0);
        rd(`SPS_LOC_PIN_GROUP, 1'b0, 16'h0001, 1'b0);
        wr(`SPS_LOC_POLL_STATE, 8'h00, 1'b1);
        // Event already gone: wait flag must still be set
        rd(`SPS_LOC_POLL_STATE, 1'b0, 16'h00F3, 1'b0);
        $display("test poll done");
    endtask

    task automatic t_state();
        pollOutEnable = 1'b0;
        pollRunEnable = 1'b1;
        pollModeCmd   = 1'b1;
        trigMain      = 16'h0000;
        trigAux       = 16'h0000;
        polledInputsDefined = 1'b0;
        latchMode     = 1'b1;
        signalLatched = 1'b0;
        pollingActive = 1'b0;
        auxGroupActive = 1'b0;
        @(negedge clk);
        pollModeCmd = 1'b0;
        rd(`SPS_LOC_POLL_STATE, 1'b1, 16'h000C, 1'b1);
        rd(`SPS_LOC_PIN_GROUP, 1'b0, 16'h0000, 1'b0);
        rd(8'h88, 1'b0, 16'h0000, 1'b1);
        $display("test state done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {cmdValid, cmdWrite, cmdWord, cmdAddr, cmdWrData} = '0;
        {runSlot, dataSlot, trigMain, trigAux, pollModeCode, pollRunSlot} = '0;
        {pollModeCmd, pollOutEnable, pollRunEnable, pollRunCmd, auxGroupActive} = '0;
        {polledInputsDefined, latchMode, signalLatched, pollWaitEvent, pollingActive} = '0;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_general();
        t_slot();
        t_trig();
        t_poll();
        t_state();
        end_sim();
    end
endmodule
